/* hdl/wdg_defs.svh */
// Purpose: constants for the watchdog down-counter block
// Assumes: 32-bit APB, one aligned word per register
// Notes: times in cycles of the 20 MHz core clock
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH
`define WDG_CTRL_ADDR 12'h0D8
`define WDG_OPT_ADDR 12'h0DC
`define WDG_CTRL_RESET 8'hFE
`define WDG_ACT_BIT 0
`define WDG_SR_BIT 1
`define WDG_PRESCALE_CYC 12'hC00
`define WDG_RST_HOLD_CYC 12'h800
`define WDG_CLK_NS 50
`endif

/* hdl/wdg_pkg.sv */
// Purpose: types for the watchdog down-counter block
// Assumes: nothing
// Notes: none
package wdg_pkg;
   typedef struct packed {
      logic hw_activation;
      logic pin_stop_option;
   } wdg_opt_t;
   typedef enum logic [1:0] {
      WDG_RUN,
      WDG_WAIT,
      WDG_STOP
   } wdg_mode_t;
endpackage

/* hdl/wdg_reset_stretch.sv */
// Purpose: hold the internal reset after its source goes away
// Assumes: source is synchronous to clk
// Notes: counter is 12 bits, enough for the hold time
`timescale 1ns/1ns
`include "wdg_defs.svh"
module wdg_reset_stretch
   import wdg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic source,
   output logic chip_reset
);
   logic [11:0] count;
   // -----------------------------
   // Delay counter
   // -----------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 12'h000;
         chip_reset <= 1'b1;
      end else if (source) begin
         count <= 12'h000;
         chip_reset <= 1'b1;
      end else if (count == `WDG_RST_HOLD_CYC - 12'h001) begin
         chip_reset <= 1'b0;
      end else if (chip_reset) begin
         count <= count + 12'h001;
      end
   end
endmodule // wdg_reset_stretch

/* hdl/wdg_top.sv */
// Purpose: digital watchdog down-counter with APB register access
// Assumes: options fixed by straps, sampled after reset release
// Notes: stop/wait requests come from the core as one-cycle pulses
`timescale 1ns/1ns
`include "wdg_defs.svh"
module wdg_top
   import wdg_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_activation_strap,
   input wire logic pin_stop_strap,
   input wire logic nmi_pin,
   input wire logic stop_request,
   input wire logic wake_interrupt,
   output logic chip_reset,
   output logic oscillator_halt,
   output logic cpu_wait,
   output logic cpu_stop
);
   // -----------------------------
   // Reset and pin synchronisers
   // -----------------------------
   logic rst_meta, rst_n;
   logic [2:0] pin_meta, pin_sync;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         pin_meta <= {nmi_pin, pin_stop_strap, hw_activation_strap};
         pin_sync <= pin_meta;
      end
   end
   wire nmi_high = pin_sync[2];
   // -----------------------------
   // Options, caught after release
   // -----------------------------
   wdg_opt_t opt;
   logic opt_taken;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         opt <= '0;
         opt_taken <= 1'b0;
      // Wait for the held reset so the strap copies have settled
      end else if (!opt_taken && !chip_reset) begin
         opt <= '{hw_activation: pin_sync[0], pin_stop_option: pin_sync[1]};
         opt_taken <= 1'b1;
      end
   end
   // -----------------------------
   // Internal chip reset
   // -----------------------------
   logic core_rst_n;
   logic timeout_rst, swr_rst;
   wdg_reset_stretch u_stretch (
      .clk(clk),
      .rst_n(rst_n),
      .source(timeout_rst | swr_rst),
      .chip_reset(chip_reset)
   );
   // Holding the counter in reset while the chip is held keeps one source
   assign core_rst_n = ~chip_reset;
   // -----------------------------
   // APB decode
   // -----------------------------
   wire ctrl_sel = paddr == `WDG_CTRL_ADDR;
   wire opt_sel = paddr == `WDG_OPT_ADDR;
   wire access = psel & penable;
   wire ctrl_wr = access & pwrite & ctrl_sel;
   assign pready = 1'b1;
   assign pslverr = access & ~(ctrl_sel | opt_sel);
   // -----------------------------
   // Counter and activate bit
   // -----------------------------
   // Counter bits: [5:0] period (lsb first), [6] software-reset bit
   logic [6:0] count;
   logic active_bit;
   logic [11:0] prescale;
   wdg_mode_t mode;
   logic [6:0] wr_count;
   // reversed mapping: reg bit 7 -> counter bit 0, reg bit 2 -> bit 5
   assign wr_count = {pwdata[`WDG_SR_BIT], pwdata[2], pwdata[3],
                      pwdata[4], pwdata[5], pwdata[6], pwdata[7]};
   wire active = active_bit | opt.hw_activation;
   wire frozen = mode == WDG_STOP;
   wire tick = !frozen && (prescale == `WDG_PRESCALE_CYC - 12'h001);
   wire [6:0] next_count = count - 7'h01;
   always_ff @(posedge clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         count <= 7'h7F;
         active_bit <= 1'b0;
         prescale <= 12'h000;
      end else if (ctrl_wr) begin
         count <= wr_count;
         prescale <= 12'h000;
         if (pwdata[`WDG_ACT_BIT])
            active_bit <= 1'b1;
      end else if (!frozen) begin
         prescale <= tick ? 12'h000 : prescale + 12'h001;
         if (tick)
            count <= next_count;
      end
   end
   // Bit 6 falling on a tick ends the period; as a timer it just wraps
   assign timeout_rst = active && tick && count[6] && !next_count[6];
   // A write dropping the software-reset bit resets even while inactive
   assign swr_rst = ctrl_wr && !pwdata[`WDG_SR_BIT];
   // -----------------------------
   // Stop and wait handling
   // -----------------------------
   logic [1:0] mode_bits;
   wire stop_is_stop = !active ||
                       (opt.pin_stop_option && nmi_high);
   always_ff @(posedge clk or negedge core_rst_n) begin
      if (!core_rst_n) begin
         mode <= WDG_RUN;
      end else begin
         case (mode)
            WDG_RUN: begin
               if (stop_request)
                  mode <= stop_is_stop ? WDG_STOP : WDG_WAIT;
            end
            WDG_WAIT, WDG_STOP: begin
               if (wake_interrupt)
                  mode <= WDG_RUN;
            end
            default: mode <= WDG_RUN;
         endcase
      end
   end
   assign cpu_stop = mode == WDG_STOP;
   assign cpu_wait = mode == WDG_WAIT;
   // Oscillator only halts when no active watchdog needs it
   assign oscillator_halt = cpu_stop && !active;
   // -----------------------------
   // Read data
   // -----------------------------
   wire [7:0] ctrl_view = {count[0], count[1], count[2], count[3],
                           count[4], count[5], count[6], active};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= ctrl_sel ? {24'h000000, ctrl_view} :
                   opt_sel ? {30'h0, opt} : 32'h0000_0000;
      end
   end
   assign mode_bits = mode;
endmodule // wdg_top

/* tb/wdg_top_assertions.sv */
// Purpose: port checks of the watchdog block
// Assumes: zero-wait APB
// Notes: bind at the foot
`timescale 1ns/1ns
`include "wdg_defs.svh"
module wdg_top_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wake_interrupt,
   input wire logic chip_reset,
   input wire logic oscillator_halt,
   input wire logic cpu_wait,
   input wire logic cpu_stop
);
   logic [15:0] hold_cnt, wr_age;
   wire logic acc = psel && penable;
   wire logic ctl_wr = acc && pwrite && paddr == `WDG_CTRL_ADDR;
   // ----
   // Ages; write age saturates, no false wrap
   // ----
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt <= '0;
         wr_age <= '0;
      end else begin
         hold_cnt <= chip_reset ? hold_cnt + 16'h1 : 16'h0;
         wr_age <= ctl_wr ? 16'h0 : wr_age + {15'h0, ~&wr_age};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_READY: assert property (acc |-> pready)
      else $error("access without ready");
   AST_UNMAPPED: assert property (acc && paddr != `WDG_CTRL_ADDR
      && paddr != `WDG_OPT_ADDR |-> pslverr) else $error("no slverr");
   AST_RD_HIGH: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_SR_CLEAR: assert property (ctl_wr && !pwdata[1] && !chip_reset
      |=> chip_reset) else $error("no reset on cleared bit");
   AST_HOLD: assert property ($fell(chip_reset) |-> hold_cnt >= 16'h800)
      else $error("reset released early");
   AST_EARLY: assert property ($rose(chip_reset) |->
      wr_age <= 16'h2 || wr_age >= 16'hBFF) else $error("early timeout");
   AST_WAKE: assert property (cpu_stop && wake_interrupt
      |-> ##[1:4] !cpu_stop) else $error("no wake from stop");
   AST_HALT: assert property (oscillator_halt |-> cpu_stop && !cpu_wait)
      else $error("halt outside stop");
endmodule // wdg_top_assertions
bind wdg_top wdg_top_assertions chk (.*);

/* tb/test_digital_watchdog_downcounter.sv */
// Purpose: self-checking bench of the watchdog block
// Assumes: zero-wait APB slave
// Notes: straps change only under reset
`timescale 1ns/1ns
`include "wdg_defs.svh"
module test_digital_watchdog_downcounter;
   logic clk = '0, reset_n = '0, psel = '0, penable = '0, pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, chip_reset, oscillator_halt, cpu_wait, cpu_stop;
   logic hw_activation_strap = '0, pin_stop_strap = '0, nmi_pin = '0;
   logic stop_request = '0, wake_interrupt = '0;
   int failures = 0, checked = 0, cycles = 0, n;
   wdg_top dut (.*);
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures++;
         report_and_stop();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic report_and_stop();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      for (int k = 0; k < 20 && pready !== 1'h1; k++) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wait_rst(input logic lvl, input int lim);
      n = 0;
      while (chip_reset !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic settle();
      wait_rst(1'h0, 2200);
      chk(32'(n >= 2048 && n < 2200), 32'h1);
   endtask
   task automatic pulse(input logic stop);
      stop_request <= stop;
      wake_interrupt <= !stop;
      @(posedge clk);
      stop_request <= 1'h0;
      wake_interrupt <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic do_reset();
      reset_n <= 1'h0;
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      settle();
      apb(1'h0, `WDG_CTRL_ADDR, 8'h0);
   endtask
   initial begin
      do_reset();
      chk(rd, 32'hFE);
      apb(1'h0, 12'h0E0, 8'h0);
      chk(32'(err), 32'h1);
      pulse(1'h1);
      chk(32'({oscillator_halt, cpu_stop, cpu_wait}), 32'h6);
      pulse(1'h0);
      chk(32'(cpu_stop), 32'h0);
      apb(1'h1, `WDG_CTRL_ADDR, 8'h02);
      wait_rst(1'h1, 4000);
      chk(32'(chip_reset), 32'h0);
      $display("inactive test done");
      apb(1'h1, `WDG_CTRL_ADDR, 8'h03);
      repeat (3) begin
         wait_rst(1'h1, 2500);
         apb(1'h1, `WDG_CTRL_ADDR, 8'h03);
      end
      chk(32'(chip_reset), 32'h0);
      apb(1'h1, `WDG_CTRL_ADDR, 8'h02);
      apb(1'h0, `WDG_CTRL_ADDR, 8'h0);
      chk(32'(rd[0]), 32'h1);
      for (int i = 1; i < 3; i++) begin
         apb(1'h1, `WDG_CTRL_ADDR, i == 1 ? 8'h03 : 8'h83);
         wait_rst(1'h1, 3072 * i + 40);
         chk(32'(n > 3072 * i - 40 && n < 3072 * i + 40), 32'h1);
         settle();
         apb(1'h0, `WDG_CTRL_ADDR, 8'h0);
         chk(rd, 32'hFE);
      end
      apb(1'h1, `WDG_CTRL_ADDR, 8'h00);
      chk(32'(chip_reset), 32'h1);
      settle();
      $display("timeout test done");
      hw_activation_strap <= 1'h1;
      pin_stop_strap <= 1'h1;
      do_reset();
      chk(rd, 32'hFF);
      apb(1'h0, `WDG_OPT_ADDR, 8'h0);
      chk(rd, 32'h3);
      apb(1'h1, `WDG_CTRL_ADDR, 8'hFE);
      apb(1'h0, `WDG_CTRL_ADDR, 8'h0);
      chk(rd, 32'hFF);
      pulse(1'h1);
      chk(32'({cpu_stop, cpu_wait}), 32'h1);
      pulse(1'h0);
      nmi_pin <= 1'h1;
      repeat (4) @(posedge clk);
      pulse(1'h1);
      chk(32'({cpu_stop, cpu_wait}), 32'h2);
      pulse(1'h0);
      chk(32'(cpu_stop), 32'h0);
      $display("option test done");
      report_and_stop();
   end
endmodule // test_digital_watchdog_downcounter
